//--- pkg/readback_regs.svh
// Operation
// - pin mode: start pin falls, clock pin shifts
// - serial readback incrementing, always from frame zero
// - dedicated start input starts on rising edge
// - before done: pin drives tristate, no readback (bus frame reads are still served here)
// - option picks pin readback or tristate
// - fabric start edge selectable rise or fall
// - clock source: fabric clock or oscillator
// - data changes on selected readback clock
// - bus readback: any frame, repeatable
// - serial and bus readback never overlap
// - frame format as config, no header
// - unmasked frames equal loaded configuration bits
// - logic cells in ram mode read zero
// - block ram contents never in frames
// - transceiver bits readable, autoconfig excluded
// - stream opens 11110010 then eight ones
// - incremental addressing: address frame omitted
// - frame: 01, zero align, data, checksum, stops
// - postamble 00, dummy ones, sixteen stops
// - device header fields never emitted
// - readback only after configuration done; bus frame reads here do not wait for done
// - security off, on default, once
// - reader finds frame by 01 pair
`ifndef READBACK_REGS_SVH
`define READBACK_REGS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define RB_ADDR_CTRL    8'h00
`define RB_ADDR_STATUS  8'h04
`define RB_ADDR_FRAME   8'h10
`define RB_ADDR_MASK    8'h20
`define RB_CTRL_RESET   8'h20
// ctrl fields
`define RB_CTRL_DONE    0
`define RB_CTRL_FABRIC  1
`define RB_CTRL_FALL    2
`define RB_CTRL_OSC     3
`define RB_CTRL_PINRB   4
`define RB_CTRL_SEC_LO  5
`define RB_CTRL_SEC_HI  6

// ----------------------------------------
// stream layout
// ----------------------------------------
`define RB_FRAMES       4
`define RB_IDX_W        2
`define RB_DATA_W       16
`define RB_HDR_BYTE     8'hF2
`define RB_STOP_BYTE    8'hFF
`define RB_FRM_LEAD     8'h40
`define RB_FRM_BITS     6'd40
`define RB_HDR_BITS     6'd16
`define RB_POST_BITS    6'd32
`define RB_POST_WORD    32'h3FFFFFFF
`define RB_ALIGN_BITS   5'd6
`define RB_FRM_LAST     5'd29

// ----------------------------------------
// timing
// ----------------------------------------
`define RB_OSC_PERIOD_NS  40
`define RB_CLK_PERIOD_NS  10
`define RB_OSC_DIV        (`RB_OSC_PERIOD_NS / `RB_CLK_PERIOD_NS)
`define RB_LINK_HALF      2'd3
`define RB_PULSE_CYC      5'd16

`endif

//--- pkg/readback_pkg.sv
package readback_pkg;
   typedef enum logic [1:0] {SEC_OFF, SEC_ON, SEC_ONCE, SEC_SPARE} security_t;
   typedef enum {DEV_IDLE, DEV_HDR, DEV_FRM, DEV_POST} dev_state_t;
   typedef enum {RDR_HUNT, RDR_SAW0, RDR_FRAME} rdr_state_t;
endpackage

//--- pkg/readback_link_if.sv
`timescale 1ns/100ps
interface readback_link_if;
   logic config_clock_pin;
   logic readback_start_n;
   logic dedicated_readback_start_in;
   logic fabric_readback_start;
   logic fabric_readback_clock;
   logic readback_data;

   modport device (
      input  config_clock_pin,
      input  readback_start_n,
      input  dedicated_readback_start_in,
      input  fabric_readback_start,
      input  fabric_readback_clock,
      output readback_data
   );
   modport reader (
      output config_clock_pin,
      output readback_start_n,
      output dedicated_readback_start_in,
      output fabric_readback_start,
      output fabric_readback_clock,
      input  readback_data
   );
endinterface

//--- design/link_edge_sync.sv
`timescale 1ns/100ps
module link_edge_sync (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // foreign level
   input  wire logic async_in,
   // synchronised view
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic last;

   // two flops, then one more to find edges
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta  <= 1'b1;
         level <= 1'b1;
         last  <= 1'b1;
      end
      else
      begin
         meta  <= async_in;
         level <= meta;
         last  <= level;
      end
   end

   assign rise = level & ~last;
   assign fall = ~level & last;
endmodule // link_edge_sync

//--- design/readback_device.sv
`timescale 1ns/100ps
`include "readback_regs.svh"
module readback_device (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // tristate control
   input  wire logic        tristate_alt_in,
   output logic             global_tristate,
   // link
   readback_link_if.device  link
);
   import readback_pkg::*;

   // ----------------------------------------
   // link inputs, two flops each
   // ----------------------------------------
   logic pin_level;
   logic pin_fall;
   logic ded_rise;
   logic fab_rise;
   logic fab_fall;
   logic fclk_rise;
   logic config_clock_pin_rise;
   logic alt_level;

   link_edge_sync u_pin (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .async_in(link.readback_start_n),
      .level   (pin_level),
      .rise    (),
      .fall    (pin_fall)
   );
   link_edge_sync u_ded (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .async_in(link.dedicated_readback_start_in),
      .level   (),
      .rise    (ded_rise),
      .fall    ()
   );
   link_edge_sync u_fab (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .async_in(link.fabric_readback_start),
      .level   (),
      .rise    (fab_rise),
      .fall    (fab_fall)
   );
   link_edge_sync u_fclk (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .async_in(link.fabric_readback_clock),
      .level   (),
      .rise    (fclk_rise),
      .fall    ()
   );
   link_edge_sync u_config_clock_pin (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .async_in(link.config_clock_pin),
      .level   (),
      .rise    (config_clock_pin_rise),
      .fall    ()
   );
   // alternate tristate source is a pin of its own, so it is synchronised too
   link_edge_sync u_alt (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .async_in(tristate_alt_in),
      .level   (alt_level),
      .rise    (),
      .fall    ()
   );

   // ----------------------------------------
   // registers and configuration memory
   // ----------------------------------------
   logic [7:0]            ctrl;
   logic                  once_used;
   logic [`RB_DATA_W-1:0] frame_mem [`RB_FRAMES];
   logic [`RB_DATA_W-1:0] ram_mask [`RB_FRAMES];
   dev_state_t            state;
   logic [`RB_IDX_W-1:0]  frame;
   logic [5:0]            bits_left;
   logic [39:0]           shreg;
   logic [3:0]            osc_cnt;

   wire       cfg_done   = ctrl[`RB_CTRL_DONE];
   wire       fab_sel    = ctrl[`RB_CTRL_FABRIC];
   wire       fall_sel   = ctrl[`RB_CTRL_FALL];
   wire       osc_sel    = ctrl[`RB_CTRL_OSC];
   wire       pin_rb     = ctrl[`RB_CTRL_PINRB];
   wire [1:0] sec        = ctrl[`RB_CTRL_SEC_HI:`RB_CTRL_SEC_LO];
   wire       busy       = (state != DEV_IDLE);

   // register decode
   wire       hit_ctrl   = (addr == `RB_ADDR_CTRL);
   wire       hit_status = (addr == `RB_ADDR_STATUS);
   wire       hit_frame  = (addr[7:4] == `RB_ADDR_FRAME >> 4) && (addr[1:0] == 2'b00);
   wire       hit_mask   = (addr[7:4] == `RB_ADDR_MASK >> 4) && (addr[1:0] == 2'b00);
   wire [1:0] widx       = addr[3:2];
   // frame reads are the bus readback path, any frame, any number of times
   wire       bus_rb     = rd & hit_frame;

   // masked frame words: ram-mode cells are forced to zero
   wire [`RB_DATA_W-1:0] rd_frame = frame_mem[widx] & ~ram_mask[widx];

   // ----------------------------------------
   // start selection
   // ----------------------------------------
   wire fab_edge  = fall_sel ? fab_fall : fab_rise;
   wire pin_start = ~fab_sel & pin_rb & pin_fall;
   wire start_evt = pin_start | (fab_sel & fab_edge) | ded_rise;
   // readback gated by done, security and a bus readback in this cycle
   wire sec_ok    = (sec == SEC_OFF) || (sec == SEC_ONCE && !once_used);
   wire start_ok  = start_evt & cfg_done & sec_ok & ~busy & ~bus_rb;

   // ----------------------------------------
   // readback clock selection
   // ----------------------------------------
   wire osc_tick  = (osc_cnt == 4'(`RB_OSC_DIV - 1));
   wire fab_tick  = osc_sel ? osc_tick : fclk_rise;
   wire tick      = fab_sel ? fab_tick : config_clock_pin_rise;

   // ----------------------------------------
   // next frame image: lead byte, data, checksum, stops
   // ----------------------------------------
   wire [`RB_IDX_W-1:0]  next_idx  = (state == DEV_HDR) ? '0 : frame + 1'b1;
   wire [`RB_DATA_W-1:0] next_data = frame_mem[next_idx] & ~ram_mask[next_idx];
   wire [7:0]            next_sum  = `RB_FRM_LEAD ^ next_data[15:8] ^ next_data[7:0];
   // no address frame: incremental addressing only
   wire [39:0] next_frm = {`RB_FRM_LEAD, next_data, next_sum, `RB_STOP_BYTE};
   wire        last_bit = tick & busy & (bits_left == 6'd1);
   wire        last_frm = (frame == `RB_IDX_W'(`RB_FRAMES - 1));

   // ----------------------------------------
   // oscillator divider
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         osc_cnt <= 4'h0;
      else
         osc_cnt <= osc_tick ? 4'h0 : osc_cnt + 4'h1;
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // configuration load writes frames; block ram and autoconfig have no place here
   always_ff @(posedge ref_clk)
   begin
      if (wr && hit_frame)
         frame_mem[widx] <= wdata[`RB_DATA_W-1:0];
      if (wr && hit_mask)
         ram_mask[widx] <= wdata[`RB_DATA_W-1:0];
   end

   // security field is fixed once configuration is done
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl <= `RB_CTRL_RESET;
      else if (wr && hit_ctrl)
         ctrl <= cfg_done ? {ctrl[7:5], wdata[4:0]} : wdata[7:0];
   end

   // ----------------------------------------
   // read data, one cycle later
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata <= 32'h0;
      else if (rd && hit_ctrl)
         rdata <= {24'h0, ctrl};
      else if (rd && hit_status)
         rdata <= {28'h0, frame, once_used, busy};
      else if (bus_rb && !busy)
         rdata <= {16'h0, rd_frame};
      else
         rdata <= 32'h0;  // unmapped, or frame read refused during serial
   end

   // ----------------------------------------
   // global tristate source
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         global_tristate <= 1'b0;
      else if (!cfg_done || !pin_rb)
         global_tristate <= ~pin_level;
      else
         global_tristate <= alt_level;
   end

   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   // header block of the stream, device header itself never sent
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state     <= DEV_IDLE;
         frame     <= '0;
         bits_left <= 6'd0;
         shreg     <= '1;
         once_used <= 1'b0;
      end
      else if (start_ok)
      begin
         state     <= DEV_HDR;
         frame     <= '0;
         bits_left <= `RB_HDR_BITS;
         shreg     <= {`RB_HDR_BYTE, `RB_STOP_BYTE, 24'hFFFFFF};
         once_used <= once_used | (sec == SEC_ONCE);
      end
      else if (last_bit)
      begin
         case (state)
            DEV_HDR, DEV_FRM:
            begin
               if (state == DEV_FRM && last_frm)
               begin
                  state     <= DEV_POST;
                  bits_left <= `RB_POST_BITS;
                  shreg     <= {`RB_POST_WORD, 8'hFF};
               end
               else
               begin
                  state     <= DEV_FRM;
                  frame     <= next_idx;
                  bits_left <= `RB_FRM_BITS;
                  shreg     <= next_frm;
               end
            end
            default:
            begin
               state     <= DEV_IDLE;
               bits_left <= 6'd0;
               shreg     <= '1;
            end
         endcase
      end
      else if (tick && busy)
      begin
         bits_left <= bits_left - 6'd1;
         shreg     <= {shreg[38:0], 1'b1};
      end
   end

   // ----------------------------------------
   // serial data out
   // ----------------------------------------
   // idles high so stop-bit hunting works from the first edge
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         link.readback_data <= 1'b1;
      else if (tick && busy)
         link.readback_data <= shreg[39];
      else if (!busy)
         link.readback_data <= 1'b1;
   end
endmodule // readback_device

//--- design/readback_reader.sv
`timescale 1ns/100ps
`include "readback_regs.svh"
module readback_reader (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // user commands
   input  wire logic start,
   input  wire logic use_fabric,
   input  wire logic fall_edge,
   // user results
   output logic      [`RB_DATA_W-1:0] frame_word,
   output logic                       frame_valid,
   output logic                       frame_bad,
   output logic                       stream_end,
   output logic                       busy,
   // link
   readback_link_if.reader            link
);
   import readback_pkg::*;

   logic [1:0]  div_cnt;
   logic        lclk;
   logic [4:0]  pulse_cnt;
   logic        data_s;
   rdr_state_t  state;
   logic [3:0]  ones;
   logic [4:0]  cnt;
   logic [23:0] acc;

   // ----------------------------------------
   // link clock from divider, 80 ns
   // ----------------------------------------
   wire toggle = (div_cnt == `RB_LINK_HALF);
   wire sample = toggle & ~lclk;
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_cnt <= 2'd0;
         lclk    <= 1'b0;
      end
      else
      begin
         div_cnt <= div_cnt + 2'd1;
         lclk    <= lclk ^ toggle;
      end
   end

   // ----------------------------------------
   // start pulse, two link periods
   // ----------------------------------------
   wire pulse = (pulse_cnt != 5'd0);
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         pulse_cnt <= 5'd0;
      else if (start && !pulse)
         pulse_cnt <= `RB_PULSE_CYC;
      else if (pulse)
         pulse_cnt <= pulse_cnt - 5'd1;
   end

   // fabric start idles high when a falling edge is wanted
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         link.readback_start_n      <= 1'b1;
         link.fabric_readback_start <= 1'b0;
      end
      else
      begin
         link.readback_start_n      <= ~(pulse & ~use_fabric);
         link.fabric_readback_start <= (pulse & use_fabric) ^ fall_edge;
      end
   end
   assign link.config_clock_pin            = lclk;
   assign link.fabric_readback_clock       = lclk;
   assign link.dedicated_readback_start_in = 1'b0;

   // ----------------------------------------
   // serial data capture
   // ----------------------------------------
   link_edge_sync u_data (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .async_in(link.readback_data),
      .level   (data_s),
      .rise    (),
      .fall    ()
   );

   wire [23:0] next_acc = {acc[22:0], data_s};
   wire [7:0]  calc_sum = `RB_FRM_LEAD ^ next_acc[23:16] ^ next_acc[15:8];
   wire        got_end  = (cnt == `RB_FRM_LAST);

   // frame hunt: eight ones, then 01 opens a frame, 00 ends the stream
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state       <= RDR_HUNT;
         ones        <= 4'd0;
         cnt         <= 5'd0;
         acc         <= 24'h0;
         frame_word  <= '0;
         frame_valid <= 1'b0;
         frame_bad   <= 1'b0;
         stream_end  <= 1'b0;
         busy        <= 1'b0;
      end
      else
      begin
         frame_valid <= 1'b0;
         frame_bad   <= 1'b0;
         stream_end  <= 1'b0;
         if (sample)
         begin
            case (state)
               RDR_HUNT:
               begin
                  if (!data_s && ones >= 4'd8)
                     state <= RDR_SAW0;
                  ones <= data_s ? (ones == 4'd8 ? ones : ones + 4'd1) : 4'd0;
               end
               RDR_SAW0:
               begin
                  ones <= 4'd0;
                  cnt  <= 5'd0;
                  if (data_s)
                     state <= RDR_FRAME;
                  else
                  begin
                     state      <= RDR_HUNT;
                     stream_end <= busy;
                     busy       <= 1'b0;
                  end
               end
               RDR_FRAME:
               begin
                  cnt <= cnt + 5'd1;
                  if (cnt >= `RB_ALIGN_BITS)
                     acc <= next_acc;
                  if (got_end)
                  begin
                     state       <= RDR_HUNT;
                     frame_word  <= next_acc[23:8];
                     frame_valid <= 1'b1;
                     frame_bad   <= (calc_sum != next_acc[7:0]);
                  end
               end
               default:
                  state <= RDR_HUNT;
            endcase
         end
         // start wins over a stream end; idle ones are dropped so the
         // header's 1111 00 cannot pass for a postamble
         if (start)
         begin
            busy <= 1'b1;
            ones <= 4'd0;
         end
      end
   end
endmodule // readback_reader

//--- bench/readback_assertions.sv
`timescale 1ns/100ps
module readback_assertions (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // link wires
   input wire logic config_clock_pin,
   input wire logic readback_start_n,
   input wire logic dedicated_readback_start_in,
   input wire logic fabric_readback_start,
   input wire logic fabric_readback_clock,
   input wire logic readback_data
);
   // ----------
   // helper logic
   // ----------
   logic       clk_q;
   logic [3:0] since_rise;
   logic [3:0] next_since_rise;

   // saturating count of cycles since the link clock rose
   assign next_since_rise = (config_clock_pin && !clk_q) ? 4'h0 :
                            (since_rise == 4'hF) ? since_rise : since_rise + 4'h1;

   // count register, parked at the top while the link is quiet
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         clk_q      <= 1'b0;
         since_rise <= 4'hF;
      end
      else
      begin
         clk_q      <= config_clock_pin;
         since_rise <= next_since_rise;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // ----------
   // link properties
   // ----------
   sequence s_start_low;
      (!readback_start_n)[*8];
   endsequence
   sequence s_clk_high;
      config_clock_pin[*4];
   endsequence

   property p_start_pulse;
      $fell(readback_start_n) |-> s_start_low ##1 s_start_low ##1 readback_start_n;
   endproperty
   property p_clk_high;
      $rose(config_clock_pin) |-> s_clk_high ##1 !config_clock_pin;
   endproperty
   property p_clk_low;
      $fell(config_clock_pin) |-> (!config_clock_pin)[*4];
   endproperty
   property p_clk_twin;
      config_clock_pin == fabric_readback_clock;
   endproperty
   property p_ded_idle;
      !dedicated_readback_start_in;
   endproperty
   property p_idle_at_start;
      $fell(readback_start_n) |-> readback_data[*4];
   endproperty
   property p_shift_on_tick;
      $changed(readback_data) |-> since_rise inside {[1:6]};
   endproperty
   property p_bit_hold;
      $changed(readback_data) |=> $stable(readback_data)[*6];
   endproperty

   a_start_pulse : assert property (p_start_pulse)
      else $error("start pulse not sixteen cycles low");
   a_clk_high : assert property (p_clk_high)
      else $error("link clock high phase not four cycles");
   a_clk_low : assert property (p_clk_low)
      else $error("link clock low phase too short");
   a_clk_twin : assert property (p_clk_twin)
      else $error("pin and fabric link clocks differ");
   a_ded_idle : assert property (p_ded_idle)
      else $error("dedicated start input not idle");
   a_idle_at_start : assert property (p_idle_at_start)
      else $error("serial data not idle high at start");
   a_shift_on_tick : assert property (p_shift_on_tick)
      else $error("serial data moved away from a link clock rise");
   a_bit_hold : assert property (p_bit_hold)
      else $error("serial bit held less than a link period");
endmodule // readback_assertions

//--- bench/config_memory_readback_tb_top.sv
`timescale 1ns/100ps
`include "readback_regs.svh"
module config_memory_readback_tb_top;
   logic                  ref_clk;
   logic                  arst_n;
   logic [7:0]            addr;
   logic [31:0]           wdata;
   logic                  wr;
   logic                  rd;
   logic [31:0]           rdata;
   logic                  tristate_alt_in;
   logic                  global_tristate;
   logic                  start;
   logic                  use_fabric;
   logic                  fall_edge;
   logic [`RB_DATA_W-1:0] frame_word;
   logic                  frame_valid;
   logic                  frame_bad;
   logic                  stream_end;
   logic                  busy;
   int                    failures;
   int                    check_count;
   logic [15:0]           fdata [4];
   logic [15:0]           fmask [4];

   // ----------
   // the two ends
   // ----------
   readback_link_if readback_link_if_inst ();
   readback_device readback_device_inst (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tristate_alt_in(tristate_alt_in),
      .global_tristate(global_tristate), .link(readback_link_if_inst));
   readback_reader readback_reader_inst (.ref_clk(ref_clk), .arst_n(arst_n), .start(start),
      .use_fabric(use_fabric), .fall_edge(fall_edge), .frame_word(frame_word),
      .frame_valid(frame_valid), .frame_bad(frame_bad), .stream_end(stream_end),
      .busy(busy), .link(readback_link_if_inst));
   readback_assertions readback_assertions_inst (.ref_clk(ref_clk), .arst_n(arst_n),
      .config_clock_pin(readback_link_if_inst.config_clock_pin),
      .readback_start_n(readback_link_if_inst.readback_start_n),
      .dedicated_readback_start_in(readback_link_if_inst.dedicated_readback_start_in),
      .fabric_readback_start(readback_link_if_inst.fabric_readback_start),
      .fabric_readback_clock(readback_link_if_inst.fabric_readback_clock),
      .readback_data(readback_link_if_inst.readback_data));

   // 100 MHz system clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ----------
   // shared tasks
   // ----------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic do_reset;
      arst_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd_reg(a, v);
      check(v, exp);
   endtask

   task automatic load;
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(`RB_ADDR_FRAME + 8'(4 * i), {16'h0000, fdata[i]});
         wr_reg(`RB_ADDR_MASK + 8'(4 * i), {16'h0000, fmask[i]});
      end
   endtask

   // one start pulse, then collect frames until the postamble or a bound
   task automatic run_stream(input int want);
      int n;
      int i;
      n = 0;
      @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      for (i = 0; i < 2500 && stream_end !== 1'b1; i++)
      begin
         @(posedge ref_clk);
         #1;
         if (frame_valid === 1'b1)
         begin
            check(frame_word, fdata[n % 4] & ~fmask[n % 4]);
            check(frame_bad, 1'b0);
            n++;
         end
      end
      check(n, want);
      check(stream_end, want != 0);
      @(posedge ref_clk);
      #1 check(busy, want == 0);
      // the device still shifts the postamble tail; a start now is refused
      repeat (300) @(posedge ref_clk);
   endtask

   // ----------
   // scenarios
   // ----------
   task automatic t_regs;
      rd_chk(`RB_ADDR_CTRL, `RB_CTRL_RESET);
      rd_chk(`RB_ADDR_STATUS, 32'h0);
      rd_chk(8'h08, 32'h0);
      wr_reg(`RB_ADDR_CTRL, 32'h68);
      rd_chk(`RB_ADDR_CTRL, 32'h68);
      $display("test regs done");
   endtask

   // start pin only steers the tristate before configuration is done
   task automatic t_not_done;
      wr_reg(`RB_ADDR_CTRL, 32'h10);
      fork
         run_stream(0);
         begin
            repeat (10) @(posedge ref_clk);
            #1 check(global_tristate, 1'b1);
         end
      join
      check(global_tristate, 1'b0);
      do_reset;
      $display("test not_done done");
   endtask

   task automatic t_locked;
      wr_reg(`RB_ADDR_CTRL, 32'h31);
      run_stream(0);
      do_reset;
      $display("test locked done");
   endtask

   task automatic t_pin;
      logic [31:0] v;
      load;
      wr_reg(`RB_ADDR_CTRL, 32'h11);
      rd_chk(`RB_ADDR_FRAME + 8'h04, 32'hBEEF);
      rd_chk(`RB_ADDR_FRAME + 8'h04, 32'hBEEF);
      tristate_alt_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 check(global_tristate, 1'b1);
      tristate_alt_in <= 1'b0;
      fork
         run_stream(4);
         begin
            repeat (300) @(posedge ref_clk);
            rd_reg(`RB_ADDR_STATUS, v);
            check(v[0], 1'b1);
            rd_chk(`RB_ADDR_FRAME, 32'h0);
         end
      join
      run_stream(4);
      $display("test pin done");
   endtask

   // fall mode is set before the idle level flips, so the flip starts nothing
   task automatic t_fabric;
      for (int e = 0; e < 2; e++)
      begin
         wr_reg(`RB_ADDR_CTRL, 32'h03 | (32'(e) << 2));
         use_fabric <= 1'b1;
         fall_edge  <= (e == 1);
         repeat (8) @(posedge ref_clk);
         run_stream(4);
      end
      use_fabric <= 1'b0;
      $display("test fabric done");
   endtask

   task automatic t_once;
      logic [31:0] v;
      do_reset;
      load;
      wr_reg(`RB_ADDR_CTRL, 32'h51);
      run_stream(4);
      wr_reg(`RB_ADDR_CTRL, 32'h11);
      rd_chk(`RB_ADDR_CTRL, 32'h51);
      rd_reg(`RB_ADDR_STATUS, v);
      check(v[1], 1'b1);
      run_stream(0);
      $display("test once done");
   endtask

   // ----------
   // main sequence and watchdog
   // ----------
   initial
   begin
      arst_n          = 1'b0;
      addr            = 8'h00;
      wdata           = 32'h0;
      wr              = 1'b0;
      rd              = 1'b0;
      tristate_alt_in = 1'b0;
      start           = 1'b0;
      use_fabric      = 1'b0;
      fall_edge       = 1'b0;
      failures        = 0;
      check_count     = 0;
      fdata           = '{16'h1234, 16'hBEEF, 16'hA5C3, 16'h8001};
      fmask           = '{16'h0000, 16'h0000, 16'h0FF0, 16'h0000};
      do_reset;
      t_regs;
      t_not_done;
      t_locked;
      t_pin;
      t_fabric;
      t_once;
      complete_run;
   end

   // the whole run needs some 17000 cycles
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      failures++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      complete_run;
   end
endmodule // config_memory_readback_tb_top
